// ### src/scp_dev.sv
// device end: dual-mode serial port, stored configuration and calibration
`timescale 1ns/100ps
module scp_dev #(
   parameter int CAL_PWR_CYC = scp_pkg::CAL_PWR_CYC,
   parameter int CAL_USR_CYC = scp_pkg::CAL_USR_CYC,
   parameter int NV_SETTLE_CYC = scp_pkg::NV_SETTLE_CYC,
   parameter logic [7:0] NV_INIT = scp_pkg::NV_RESET
) (
   input wire logic ref_clk,
   input wire logic reset,
   scp_link_if.dev link,
   output logic [1:0] gain_code,
   output logic bank_sel,
   output logic corner_low,
   output logic cal_busy,
   output logic cal_done,
   output logic nv_busy
);
   localparam int CW = $clog2(CAL_PWR_CYC + 1);
   localparam int NW = $clog2(NV_SETTLE_CYC + 1);

   if (CAL_USR_CYC < 1 || CAL_PWR_CYC < CAL_USR_CYC || NV_SETTLE_CYC < 1) begin : g_chk
      $error("scp_dev: calibration or settle counts out of range");
   end

   function automatic scp_pkg::scp_tap_e tap_step(input scp_pkg::scp_tap_e s, input logic m);
      case (s)
         scp_pkg::TAP_TLR: tap_step = m ? scp_pkg::TAP_TLR : scp_pkg::TAP_RTI;
         scp_pkg::TAP_RTI: tap_step = m ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_RTI;
         scp_pkg::TAP_SEL_DR: tap_step = m ? scp_pkg::TAP_SEL_IR : scp_pkg::TAP_CAP_DR;
         scp_pkg::TAP_CAP_DR: tap_step = m ? scp_pkg::TAP_EX1_DR : scp_pkg::TAP_SH_DR;
         scp_pkg::TAP_SH_DR: tap_step = m ? scp_pkg::TAP_EX1_DR : scp_pkg::TAP_SH_DR;
         scp_pkg::TAP_EX1_DR: tap_step = m ? scp_pkg::TAP_UPD_DR : scp_pkg::TAP_PAU_DR;
         scp_pkg::TAP_PAU_DR: tap_step = m ? scp_pkg::TAP_EX2_DR : scp_pkg::TAP_PAU_DR;
         scp_pkg::TAP_EX2_DR: tap_step = m ? scp_pkg::TAP_UPD_DR : scp_pkg::TAP_SH_DR;
         scp_pkg::TAP_UPD_DR: tap_step = m ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_RTI;
         scp_pkg::TAP_SEL_IR: tap_step = m ? scp_pkg::TAP_TLR : scp_pkg::TAP_CAP_IR;
         scp_pkg::TAP_CAP_IR: tap_step = m ? scp_pkg::TAP_EX1_IR : scp_pkg::TAP_SH_IR;
         scp_pkg::TAP_SH_IR: tap_step = m ? scp_pkg::TAP_EX1_IR : scp_pkg::TAP_SH_IR;
         scp_pkg::TAP_EX1_IR: tap_step = m ? scp_pkg::TAP_UPD_IR : scp_pkg::TAP_PAU_IR;
         scp_pkg::TAP_PAU_IR: tap_step = m ? scp_pkg::TAP_EX2_IR : scp_pkg::TAP_PAU_IR;
         scp_pkg::TAP_EX2_IR: tap_step = m ? scp_pkg::TAP_UPD_IR : scp_pkg::TAP_SH_IR;
         scp_pkg::TAP_UPD_IR: tap_step = m ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_RTI;
         default: tap_step = scp_pkg::TAP_TLR;
      endcase
   endfunction

   // pin synchroniser: only the second stage and the edge history are read
   logic [scp_pkg::PIN_W-1:0] meta_r;
   logic [scp_pkg::PIN_W-1:0] pin_r;
   logic [scp_pkg::PIN_W-1:0] prev_r;
   logic [scp_pkg::PIN_W-1:0] pins;

   assign pins = {link.serial_mode_select, link.cal_req, link.cs_n, link.tms, link.sdi,
                  link.sck};

   always_ff @(posedge ref_clk) begin
      meta_r <= pins;
      pin_r <= meta_r;
      prev_r <= pin_r;
   end

   logic [scp_pkg::PIN_W-1:0] rise;
   logic [scp_pkg::PIN_W-1:0] fall;
   logic spi_mode;
   assign rise = pin_r & ~prev_r;
   assign fall = ~pin_r & prev_r;
   assign spi_mode = pin_r[scp_pkg::PIN_MODE];

   scp_pkg::scp_tap_e tap_r, tap_nxt;
   logic [scp_pkg::IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
   logic [7:0] dr_sh_r, dr_sh_nxt, dr_upd_r, dr_upd_nxt;
   logic [7:0] nv_r, nv_nxt, spi_sh_r, spi_sh_nxt, spi_ctrl_r, spi_ctrl_nxt;
   logic erased_r, erased_nxt, sdo_r, sdo_nxt;
   logic [NW-1:0] nv_cnt_r, nv_cnt_nxt;
   logic cal_busy_r, cal_busy_nxt, cal_pwr_r, cal_pwr_nxt, cal_done_r, cal_done_nxt;
   logic [CW-1:0] cal_cnt_r, cal_cnt_nxt, cal_lim;
   logic [1:0] gain_r, gain_nxt;
   logic bank_r, bank_nxt, corner_r, corner_nxt, nvb_r, nvb_nxt;
   logic cal_req;

   always_comb begin
      tap_nxt = tap_r;
      ir_nxt = ir_r;
      ir_sh_nxt = ir_sh_r;
      dr_sh_nxt = dr_sh_r;
      dr_upd_nxt = dr_upd_r;
      nv_nxt = nv_r;
      erased_nxt = erased_r;
      nv_cnt_nxt = '0;
      spi_sh_nxt = spi_sh_r;
      spi_ctrl_nxt = spi_ctrl_r;
      sdo_nxt = sdo_r;
      cal_req = 1'b0;
      if (spi_mode) begin
         // test mode select is not looked at here; the access port stands still
         if (rise[scp_pkg::PIN_SCK] && !pin_r[scp_pkg::PIN_CS]) begin
            spi_sh_nxt = {spi_sh_r[6:0], pin_r[scp_pkg::PIN_SDI]};
         end
         if (rise[scp_pkg::PIN_CS]) begin
            spi_ctrl_nxt = spi_sh_r;
            cal_req = spi_sh_r[scp_pkg::F_CAL];
         end
         sdo_nxt = spi_sh_r[7];
      end else begin
         if (rise[scp_pkg::PIN_SCK]) begin
            tap_nxt = tap_step(tap_r, pin_r[scp_pkg::PIN_TMS]);
            case (tap_r)
               scp_pkg::TAP_TLR: ir_nxt = scp_pkg::IR_BYPASS;
               scp_pkg::TAP_CAP_IR: ir_sh_nxt = scp_pkg::IR_CAPTURE;
               scp_pkg::TAP_SH_IR: ir_sh_nxt = {pin_r[scp_pkg::PIN_SDI], ir_sh_r[1]};
               scp_pkg::TAP_UPD_IR: ir_nxt = ir_sh_r;
               scp_pkg::TAP_CAP_DR: dr_sh_nxt = nv_r;
               scp_pkg::TAP_SH_DR: dr_sh_nxt = {pin_r[scp_pkg::PIN_SDI], dr_sh_r[7:1]};
               scp_pkg::TAP_UPD_DR: dr_upd_nxt = dr_sh_r;
               default: ;
            endcase
         end
         if (fall[scp_pkg::PIN_SCK]) begin
            if (tap_r == scp_pkg::TAP_SH_IR) begin
               sdo_nxt = ir_sh_r[0];
            end else if (tap_r == scp_pkg::TAP_SH_DR) begin
               sdo_nxt = dr_sh_r[0];
            end else begin
               sdo_nxt = 1'b0;
            end
         end
         // erased cells read as ones, which is the tenfold gain code
         if (tap_r == scp_pkg::TAP_RTI && ir_r == scp_pkg::IR_ERASE) begin
            nv_nxt = scp_pkg::NV_ERASED;
            erased_nxt = 1'b1;
         end
         // the host keeps idling after settle; only the settle point matters here
         if (tap_r == scp_pkg::TAP_RTI && ir_r == scp_pkg::IR_PROG) begin
            if (nv_cnt_r == NW'(NV_SETTLE_CYC - 1)) begin
               nv_nxt = dr_upd_r;
               erased_nxt = 1'b0;
               nv_cnt_nxt = nv_cnt_r;
            end else begin
               nv_cnt_nxt = nv_cnt_r + NW'(1);
            end
         end
      end
      if (rise[scp_pkg::PIN_CAL]) begin
         cal_req = 1'b1;
      end
   end

   always_comb begin
      cal_busy_nxt = cal_busy_r;
      cal_pwr_nxt = cal_pwr_r;
      cal_cnt_nxt = cal_cnt_r;
      cal_done_nxt = 1'b0;
      cal_lim = cal_pwr_r ? CW'(CAL_PWR_CYC - 1) : CW'(CAL_USR_CYC - 1);
      if (cal_busy_r) begin
         if (cal_cnt_r == cal_lim) begin
            cal_busy_nxt = 1'b0;
            cal_done_nxt = 1'b1;
            cal_cnt_nxt = '0;
         end else begin
            cal_cnt_nxt = cal_cnt_r + CW'(1);
         end
      end else if (cal_req) begin
         cal_busy_nxt = 1'b1;
         cal_pwr_nxt = 1'b0;
         cal_cnt_nxt = '0;
      end
      if (spi_mode) begin
         gain_nxt = {spi_ctrl_r[scp_pkg::F_GAIN_HI], spi_ctrl_r[scp_pkg::F_GAIN_LO]};
         bank_nxt = spi_ctrl_r[scp_pkg::F_BANK];
      end else begin
         gain_nxt = {nv_r[scp_pkg::F_GAIN_HI], nv_r[scp_pkg::F_GAIN_LO]};
         bank_nxt = nv_r[scp_pkg::F_BANK];
      end
      corner_nxt = !spi_mode && erased_r;
      nvb_nxt = !spi_mode && tap_r == scp_pkg::TAP_RTI &&
                (ir_r == scp_pkg::IR_ERASE || ir_r == scp_pkg::IR_PROG);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tap_r <= scp_pkg::TAP_TLR;
         ir_r <= scp_pkg::IR_BYPASS;
         ir_sh_r <= '0;
         dr_sh_r <= '0;
         dr_upd_r <= '0;
         nv_r <= NV_INIT;
         erased_r <= 1'b0;
         nv_cnt_r <= '0;
         spi_sh_r <= scp_pkg::SPI_RESET;
         spi_ctrl_r <= scp_pkg::SPI_RESET;
         sdo_r <= 1'b0;
         cal_busy_r <= 1'b1;
         cal_pwr_r <= 1'b1;
         cal_cnt_r <= '0;
         cal_done_r <= 1'b0;
         gain_r <= 2'h0;
         bank_r <= 1'b0;
         corner_r <= 1'b0;
         nvb_r <= 1'b0;
      end else begin
         tap_r <= tap_nxt;
         ir_r <= ir_nxt;
         ir_sh_r <= ir_sh_nxt;
         dr_sh_r <= dr_sh_nxt;
         dr_upd_r <= dr_upd_nxt;
         nv_r <= nv_nxt;
         erased_r <= erased_nxt;
         nv_cnt_r <= nv_cnt_nxt;
         spi_sh_r <= spi_sh_nxt;
         spi_ctrl_r <= spi_ctrl_nxt;
         sdo_r <= sdo_nxt;
         cal_busy_r <= cal_busy_nxt;
         cal_pwr_r <= cal_pwr_nxt;
         cal_cnt_r <= cal_cnt_nxt;
         cal_done_r <= cal_done_nxt;
         gain_r <= gain_nxt;
         bank_r <= bank_nxt;
         corner_r <= corner_nxt;
         nvb_r <= nvb_nxt;
      end
   end

   assign link.sdo = sdo_r;
   assign gain_code = gain_r;
   assign bank_sel = bank_r;
   assign corner_low = corner_r;
   assign cal_busy = cal_busy_r;
   assign cal_done = cal_done_r;
   assign nv_busy = nvb_r;
endmodule // scp_dev

// ### src/scp_host.sv
// host end: serial clock divider, word and scan sequencer, idle dwell
`timescale 1ns/100ps
module scp_host #(
   parameter int DWELL_CYC = scp_pkg::NV_DWELL_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   scp_link_if.host link,
   input wire logic mode_sel,
   input wire logic op_start,
   input wire logic [1:0] op_kind,
   input wire logic [7:0] op_word,
   input wire logic cal_start,
   output logic busy,
   output logic [7:0] rx_word
);
   localparam int DW = $clog2(scp_pkg::NV_DWELL_MAX_CYC + 1);
   localparam int VW = $clog2(scp_pkg::SCK_PER_CYC);

   if (DWELL_CYC < 1 || DWELL_CYC > scp_pkg::NV_DWELL_MAX_CYC) begin : g_chk
      $error("scp_host: dwell count out of range");
   end

   function automatic logic [31:0] msb_first(input logic [7:0] w);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < 8; i++) begin
         v[i] = w[7 - i];
      end
      return v;
   endfunction

   logic sdo_meta_r, sdo_r;
   always_ff @(posedge ref_clk) begin
      sdo_meta_r <= link.sdo;
      sdo_r <= sdo_meta_r;
   end

   scp_pkg::scp_host_e st_r, st_nxt;
   logic sck_r, sck_nxt, tms_r, tms_nxt, tdi_r, tdi_nxt, cs_n_r, cs_n_nxt;
   logic cal_r, cal_nxt, mode_r, mode_nxt, busy_r, busy_nxt, spi_r, spi_nxt;
   logic [31:0] tms_v_r, tms_v_nxt, tdi_v_r, tdi_v_nxt;
   logic [4:0] idx_r, idx_nxt, len_r, len_nxt;
   logic [VW-1:0] div_r, div_nxt;
   logic [DW-1:0] dw_r, dw_nxt;
   logic [7:0] rx_r, rx_nxt;

   always_comb begin
      st_nxt = st_r;
      sck_nxt = sck_r;
      tms_nxt = tms_r;
      tdi_nxt = tdi_r;
      cs_n_nxt = cs_n_r;
      cal_nxt = cal_r;
      mode_nxt = mode_r;
      spi_nxt = spi_r;
      tms_v_nxt = tms_v_r;
      tdi_v_nxt = tdi_v_r;
      idx_nxt = idx_r;
      len_nxt = len_r;
      div_nxt = div_r + VW'(1);
      dw_nxt = dw_r;
      rx_nxt = rx_r;
      case (st_r)
         scp_pkg::H_IDLE: begin
            // the mode pin only moves between operations
            mode_nxt = mode_sel;
            div_nxt = '0;
            if (cal_start) begin
               cal_nxt = 1'b1;
               st_nxt = scp_pkg::H_CAL;
            end else if (op_start) begin
               idx_nxt = '0;
               st_nxt = scp_pkg::H_SHIFT;
               spi_nxt = (op_kind == scp_pkg::OP_SPI);
               if (op_kind == scp_pkg::OP_SPI) begin
                  tms_v_nxt = '0;
                  tdi_v_nxt = msb_first(op_word);
                  len_nxt = scp_pkg::LEN_SPI;
                  cs_n_nxt = 1'b0;
               end else if (op_kind == scp_pkg::OP_PROG) begin
                  tms_v_nxt = scp_pkg::TMS_PAT;
                  tdi_v_nxt = {7'h00, op_word, 5'h00, scp_pkg::IR_PROG, 10'h000};
                  len_nxt = scp_pkg::LEN_PROG;
               end else begin
                  tms_v_nxt = scp_pkg::TMS_PAT;
                  tdi_v_nxt = {20'h00000, scp_pkg::IR_ERASE, 10'h000};
                  len_nxt = scp_pkg::LEN_ERASE;
               end
            end
         end
         scp_pkg::H_SHIFT: begin
            if (div_r == '0) begin
               tms_nxt = tms_v_r[idx_r];
               tdi_nxt = tdi_v_r[idx_r];
            end else if (div_r == VW'(scp_pkg::SCK_HALF_CYC)) begin
               sck_nxt = 1'b1;
               rx_nxt = {rx_r[6:0], sdo_r};
            end else if (div_r == VW'(scp_pkg::SCK_PER_CYC - 1)) begin
               sck_nxt = 1'b0;
               idx_nxt = idx_r + 5'h01;
               if (idx_r == len_r - 5'h01) begin
                  dw_nxt = '0;
                  st_nxt = spi_r ? scp_pkg::H_LATCH : scp_pkg::H_DWELL;
               end
            end
         end
         scp_pkg::H_LATCH: begin
            if (div_r == VW'(scp_pkg::SCK_HALF_CYC - 1)) begin
               cs_n_nxt = 1'b1;
            end else if (div_r == VW'(scp_pkg::SCK_PER_CYC - 1)) begin
               st_nxt = scp_pkg::H_IDLE;
            end
         end
         scp_pkg::H_DWELL: begin
            // the port sits in run-test/idle with the clock stopped
            tms_nxt = 1'b0;
            if (dw_r == DW'(DWELL_CYC - 1)) begin
               st_nxt = scp_pkg::H_IDLE;
            end else begin
               dw_nxt = dw_r + DW'(1);
            end
         end
         scp_pkg::H_CAL: begin
            if (div_r == VW'(scp_pkg::SCK_HALF_CYC - 1)) begin
               cal_nxt = 1'b0;
               st_nxt = scp_pkg::H_IDLE;
            end
         end
         default: st_nxt = scp_pkg::H_IDLE;
      endcase
      busy_nxt = (st_nxt != scp_pkg::H_IDLE);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= scp_pkg::H_IDLE;
         sck_r <= 1'b0;
         tms_r <= 1'b0;
         tdi_r <= 1'b0;
         cs_n_r <= 1'b1;
         cal_r <= 1'b0;
         mode_r <= 1'b0;
         spi_r <= 1'b0;
         busy_r <= 1'b0;
         tms_v_r <= '0;
         tdi_v_r <= '0;
         idx_r <= '0;
         len_r <= '0;
         div_r <= '0;
         dw_r <= '0;
         rx_r <= '0;
      end else begin
         st_r <= st_nxt;
         sck_r <= sck_nxt;
         tms_r <= tms_nxt;
         tdi_r <= tdi_nxt;
         cs_n_r <= cs_n_nxt;
         cal_r <= cal_nxt;
         mode_r <= mode_nxt;
         spi_r <= spi_nxt;
         busy_r <= busy_nxt;
         tms_v_r <= tms_v_nxt;
         tdi_v_r <= tdi_v_nxt;
         idx_r <= idx_nxt;
         len_r <= len_nxt;
         div_r <= div_nxt;
         dw_r <= dw_nxt;
         rx_r <= rx_nxt;
      end
   end

   assign link.sck = sck_r;
   assign link.tms = tms_r;
   assign link.sdi = tdi_r;
   assign link.cs_n = cs_n_r;
   assign link.cal_req = cal_r;
   assign link.serial_mode_select = mode_r;
   assign busy = busy_r;
   assign rx_word = rx_r;
endmodule // scp_host

// ### src/scp_link_if.sv
// serial pins between the configuration port and its host
`timescale 1ns/100ps
interface scp_link_if;
   logic sck;
   logic sdi;
   logic sdo;
   logic tms;
   logic cs_n;
   logic cal_req;
   logic serial_mode_select;
   modport dev (
      input sck,
      input sdi,
      input tms,
      input cs_n,
      input cal_req,
      input serial_mode_select,
      output sdo
   );
   modport host (
      output sck,
      output sdi,
      output tms,
      output cs_n,
      output cal_req,
      output serial_mode_select,
      input sdo
   );
endinterface

// ### src/scp_pkg.sv
// shared constants and types for the serial configuration port and its host
// Notes on behaviour
// - mode pin high selects shift-and-latch mode
// - test mode select honoured only in test-access mode
// - one serial clock drives both port modes
// - same data in and out pins both modes
// - test-access data on falling clock, latch on select rise
// - select rising edge latches shifted control word
// - calibration pin rising edge or latched control word cal bit starts calibration
// - programmer holds idle 80 to 100 ms programming
// - programmer holds idle 80 to 100 ms erasing
// - power-up calibration runs unasked, within 250 ms
// - requested calibration completes within 100 ms
// - programming cycle erases first then rewrites; the prog op here only rewrites, erase is a separate op
// - erase forces tenfold gain, lowers corner until rewrite; here only in test-access mode, not in shift-and-latch mode
// - bits settle in 2 ms, write kept 80 ms
// - power-on clears control word: gain 1, bank A
// - word: four ignored, cal, bank, gain high, low
// - gain codes 00,01,10,11 give 1,2,5,10
package scp_pkg;
   localparam int CLK_NS = 100;
   localparam int T_SCK_NS = 800;
   localparam int SCK_HALF_CYC = T_SCK_NS / (2 * CLK_NS);
   localparam int SCK_PER_CYC = 2 * SCK_HALF_CYC;
   localparam int T_CAL_PWR_MS = 250;
   localparam int CAL_PWR_CYC = T_CAL_PWR_MS * 1000000 / CLK_NS;
   localparam int T_CAL_USR_MS = 100;
   localparam int CAL_USR_CYC = T_CAL_USR_MS * 1000000 / CLK_NS;
   localparam int T_NV_SETTLE_MS = 2;
   localparam int NV_SETTLE_CYC = T_NV_SETTLE_MS * 1000000 / CLK_NS;
   localparam int T_NV_DWELL_MS = 80;
   localparam int NV_DWELL_CYC = (T_NV_DWELL_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int T_NV_DWELL_MAX_MS = 100;
   localparam int NV_DWELL_MAX_CYC = T_NV_DWELL_MAX_MS * 1000000 / CLK_NS;
   // pin positions in the synchronised input vector
   localparam int PIN_SCK = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_TMS = 2;
   localparam int PIN_CS = 3;
   localparam int PIN_CAL = 4;
   localparam int PIN_MODE = 5;
   localparam int PIN_W = 6;
   // control word and stored configuration share one layout
   localparam int WORD_W = 8;
   localparam int F_GAIN_LO = 0;
   localparam int F_GAIN_HI = 1;
   localparam int F_BANK = 2;
   localparam int F_CAL = 3;
   localparam logic [7:0] SPI_RESET = 8'h00;
   localparam logic [7:0] NV_RESET = 8'h00;
   localparam logic [7:0] NV_ERASED = 8'hFF;
   localparam int IR_W = 2;
   localparam logic [1:0] IR_READ = 2'h0;
   localparam logic [1:0] IR_ERASE = 2'h1;
   localparam logic [1:0] IR_PROG = 2'h2;
   localparam logic [1:0] IR_BYPASS = 2'h3;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam logic [1:0] OP_SPI = 2'h0;
   localparam logic [1:0] OP_ERASE = 2'h1;
   localparam logic [1:0] OP_PROG = 2'h2;
   // host scan vectors, bit i is sent before serial clock edge i
   localparam logic [31:0] TMS_PAT = 32'h030058DF;
   localparam logic [4:0] LEN_SPI = 5'h08;
   localparam logic [4:0] LEN_ERASE = 5'h0E;
   localparam logic [4:0] LEN_PROG = 5'h1B;
   typedef enum logic [3:0] {
      TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
      TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
      TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
      TAP_EX1_IR = 4'hC, TAP_PAU_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
   } scp_tap_e;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_SHIFT = 3'h1, H_LATCH = 3'h2, H_DWELL = 3'h3, H_CAL = 3'h4
   } scp_host_e;
endpackage

// ### verif/scp_link_sva.sv
// protocol assertions on the serial pins between host and device ends
`timescale 1ns/100ps
module scp_link_sva (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sck,
   input wire logic sdi,
   input wire logic tms,
   input wire logic cs_n,
   input wire logic cal_req,
   input wire logic serial_mode_select
);
   logic sck_d_r;
   logic [3:0] rise_cnt_r;
   logic [3:0] rise_cnt_nxt;
   // saturates so a runaway frame cannot wrap back to a legal count
   always_comb begin
      rise_cnt_nxt = rise_cnt_r;
      if (cs_n) begin
         rise_cnt_nxt = 4'h0;
      end else if (sck && !sck_d_r && rise_cnt_r != 4'hF) begin
         rise_cnt_nxt = rise_cnt_r + 4'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      sck_d_r <= reset ? 1'b0 : sck;
      rise_cnt_r <= reset ? 4'h0 : rise_cnt_nxt;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence sck_hold_hi;
      sck [*3];
   endsequence
   sequence sck_hold_lo;
      !sck [*3];
   endsequence
   sequence cal_pulse;
      cal_req [*4] ##1 !cal_req;
   endsequence
   sck_high_a: assert property ($rose(sck) |-> sck_hold_hi)
      else $error("serial clock high phase too short");
   sck_low_a: assert property ($fell(sck) |-> sck_hold_lo)
      else $error("serial clock low phase too short");
   sdi_hold_a: assert property (sck |-> $stable(sdi))
      else $error("serial data moved while clock high");
   tms_hold_a: assert property (sck |-> $stable(tms))
      else $error("mode select moved while clock high");
   frame_clock_a: assert property ($rose(sck) && serial_mode_select |-> !cs_n)
      else $error("serial clock outside a select frame");
   latch_quiet_a: assert property ($rose(cs_n) |-> !sck && !$past(sck))
      else $error("select released near a clock high");
   word_len_a: assert property ($rose(cs_n) && serial_mode_select |-> rise_cnt_r == 4'h8)
      else $error("control frame not eight clocks");
   cal_pulse_a: assert property ($rose(cal_req) |-> cal_pulse)
      else $error("calibration request pulse malformed");
   reset_idle_a: assert property ($fell(reset) |-> !sck && cs_n && !cal_req)
      else $error("link not idle after reset");
endmodule // scp_link_sva

// ### verif/serial_config_port_cal_control_test.sv
// self-checking bench: host end and device end joined over the serial link
`timescale 1ns/100ps
module serial_config_port_cal_control_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic mode_sel = 1'b0;
   logic op_start = 1'b0;
   logic [1:0] op_kind = 2'h0;
   logic [7:0] op_word = 8'h00;
   logic cal_start = 1'b0;
   logic busy, bank_sel, corner_low, cal_busy, cal_done, nv_busy;
   logic [7:0] rx_word;
   logic [1:0] gain_code;
   logic saw_nv = 1'b0;
   int err_count = 0;
   int cmp_count = 0;
   scp_link_if link ();
   scp_dev #(.CAL_PWR_CYC(200), .CAL_USR_CYC(100), .NV_SETTLE_CYC(50)) i_scp_dev (
      .ref_clk(ref_clk), .reset(reset), .link(link), .gain_code(gain_code),
      .bank_sel(bank_sel), .corner_low(corner_low), .cal_busy(cal_busy),
      .cal_done(cal_done), .nv_busy(nv_busy));
   scp_host #(.DWELL_CYC(100)) i_scp_host (
      .ref_clk(ref_clk), .reset(reset), .link(link), .mode_sel(mode_sel),
      .op_start(op_start), .op_kind(op_kind), .op_word(op_word),
      .cal_start(cal_start), .busy(busy), .rx_word(rx_word));
   scp_link_sva i_scp_link_sva (
      .ref_clk(ref_clk), .reset(reset), .sck(link.sck), .sdi(link.sdi), .tms(link.tms),
      .cs_n(link.cs_n), .cal_req(link.cal_req),
      .serial_mode_select(link.serial_mode_select));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic set_mode(input logic m);
      mode_sel <= m;
      repeat (10) @(posedge ref_clk);
   endtask
   task automatic run_op(input logic [1:0] k, input logic [7:0] w);
      int n;
      n = 0;
      op_kind <= k;
      op_word <= w;
      op_start <= 1'b1;
      @(posedge ref_clk);
      op_start <= 1'b0;
      @(posedge ref_clk);
      while (busy !== 1'b0 && n < 2000) begin
         // early scan bits may still show the previous operation's idle state
         if (n > 40 && nv_busy === 1'b1) saw_nv = 1'b1;
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000) err_count++;
      // settle time covers pin synchronisers and output update
      repeat (10) @(posedge ref_clk);
   endtask
   task automatic pulse_cal();
      cal_start <= 1'b1;
      @(posedge ref_clk);
      cal_start <= 1'b0;
   endtask
   task automatic wait_done(output int n);
      n = 0;
      while (cal_done !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic test_power();
      int n;
      chk({4'h0, corner_low, bank_sel, gain_code}, 8'h00);
      chk({7'h0, cal_busy}, 8'h01);
      wait_done(n);
      chk(8'(n >= 190 && n <= 220), 8'h01);
      $display("test power done");
   endtask
   task automatic test_spi();
      logic [7:0] w, prev;
      set_mode(1'b1);
      prev = 8'h00;
      for (int i = 0; i < 4; i++) begin
         w = 8'hA0 | 8'(i) | (i[0] ? 8'h00 : 8'h04);
         run_op(scp_pkg::OP_SPI, w);
         chk({6'h0, gain_code}, {6'h0, w[1:0]});
         chk({7'h0, bank_sel}, {7'h0, w[2]});
         chk(rx_word, prev);
         prev = w;
      end
      $display("test spi done");
   endtask
   task automatic test_cal_pin();
      int n;
      pulse_cal();
      repeat (20) @(posedge ref_clk);
      chk({7'h0, cal_busy}, 8'h01);
      pulse_cal();
      wait_done(n);
      chk(8'(n >= 70 && n <= 95), 8'h01);
      repeat (30) @(posedge ref_clk);
      chk({7'h0, cal_busy}, 8'h00);
      $display("test cal pin done");
   endtask
   task automatic test_spi_cal();
      int n;
      run_op(scp_pkg::OP_SPI, 8'h5B);
      chk({5'h00, cal_busy, gain_code}, 8'h07);
      wait_done(n);
      chk(8'(n >= 70 && n <= 100), 8'h01);
      $display("test spi cal done");
   endtask
   task automatic test_nv();
      set_mode(1'b0);
      chk({4'h0, corner_low, bank_sel, gain_code}, 8'h00);
      saw_nv = 1'b0;
      run_op(scp_pkg::OP_ERASE, 8'h00);
      chk({7'h0, saw_nv}, 8'h01);
      chk({4'h0, corner_low, bank_sel, gain_code}, 8'h0F);
      saw_nv = 1'b0;
      run_op(scp_pkg::OP_PROG, 8'h05);
      chk({7'h0, saw_nv}, 8'h01);
      chk({4'h0, corner_low, bank_sel, gain_code}, 8'h05);
      set_mode(1'b1);
      chk({4'h0, corner_low, bank_sel, gain_code}, 8'h03);
      $display("test nv done");
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      test_power();
      test_spi();
      test_cal_pin();
      test_spi_cal();
      test_nv();
      final_report();
   end
   // all tests need under 3000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      final_report();
   end
endmodule // serial_config_port_cal_control_test
